/* core/mbsp_cmp_if.sv */
// Companding signals between the port core and the companding unit.
// Purely combinational path; both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface mbsp_cmp_if;
  logic aLaw;
  logic [15:0] txLinear;
  logic [7:0] txCode;
  logic [7:0] rxCode;
  logic [15:0] rxLinear;
  modport core (output aLaw, output txLinear, output rxCode,
                input txCode, input rxLinear);
  modport codec (input aLaw, input txLinear, input rxCode,
                 output txCode, output rxLinear);
endinterface : mbsp_cmp_if
`default_nettype wire

/* core/mbsp_compand.sv */
// Mu-law and A-law compression of 16-bit linear words and expansion back.
// Assumes the core selects the law and only uses results for 8-bit words.
`timescale 1ns/1ns
`default_nettype none
module mbsp_compand (
  mbsp_cmp_if.codec cmp
);
  localparam logic [15:0] MU_CLIP = 16'h1FDE;
  localparam logic [15:0] MU_BIAS = 16'h0021;
  localparam logic [15:0] MU_DBIAS = 16'h0084;

  function automatic logic [7:0] muEnc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0] e;
    mag = (x[15] ? ~x : x) >> 2;
    if (mag > MU_CLIP) mag = MU_CLIP;
    mag = mag + MU_BIAS;
    e = 3'h0;
    for (int i = 5; i <= 12; i++) if (mag[i]) e = 3'(i - 5);
    return ~{x[15], e, 4'(mag >> ({1'b0, e} + 4'h1))};
  endfunction : muEnc

  function automatic logic [7:0] aEnc(input logic [15:0] x);
    logic [15:0] mag;
    logic [2:0] e;
    mag = (x[15] ? ~x : x) >> 3;
    e = 3'h0;
    for (int i = 5; i <= 11; i++) if (mag[i]) e = 3'(i - 4);
    if (e == 3'h0) return {~x[15], 3'h0, mag[4:1]} ^ 8'h55;
    return {~x[15], e, 4'(mag >> e)} ^ 8'h55;
  endfunction : aEnc

  function automatic logic [15:0] muDec(input logic [7:0] code);
    logic [7:0] c;
    logic [15:0] mag;
    c = ~code;
    mag = (({9'h000, c[3:0], 3'h0}) + MU_DBIAS) << c[6:4];
    mag = mag - MU_DBIAS;
    return c[7] ? (~mag + 16'h0001) : mag;
  endfunction : muDec

  function automatic logic [15:0] aDec(input logic [7:0] code);
    logic [7:0] c;
    logic [15:0] mag;
    c = code ^ 8'h55;
    mag = {8'h00, c[3:0], 4'h8};
    if (c[6:4] != 3'h0) mag = (mag + 16'h0100) << (c[6:4] - 3'h1);
    return c[7] ? mag : (~mag + 16'h0001);
  endfunction : aDec

  always_comb begin
    cmp.txCode = cmp.aLaw ? aEnc(cmp.txLinear) : muEnc(cmp.txLinear);
    cmp.rxLinear = cmp.aLaw ? aDec(cmp.rxCode) : muDec(cmp.rxCode);
  end
endmodule : mbsp_compand
`default_nettype wire

/* core/mbsp_pkg.sv */
// Register map, field positions and reset values of the buffered serial port.
// Assumes byte addressing on the register bus, one 32-bit word per register.
package mbsp_pkg;
  // ==========================================================================
  // Register byte offsets
  localparam logic [5:0] OFF_CTRL = 6'h00;
  localparam logic [5:0] OFF_CLKCFG = 6'h04;
  localparam logic [5:0] OFF_TXDATA = 6'h08;
  localparam logic [5:0] OFF_RXDATA = 6'h0C;
  localparam logic [5:0] OFF_STATUS = 6'h10;
  localparam logic [5:0] OFF_MASK = 6'h14;
  localparam logic [5:0] OFF_TXCHEN = 6'h18;
  localparam logic [5:0] OFF_RXCHEN = 6'h1C;
  localparam logic [5:0] OFF_CHBASE = 6'h20;
  // ==========================================================================
  // Control fields
  localparam int CTRL_TXEN = 0;
  localparam int CTRL_RXEN = 1;
  localparam int CTRL_WLEN = 2;
  localparam int CTRL_CMPEN = 5;
  localparam int CTRL_ALAW = 6;
  localparam int CTRL_MULTI = 7;
  localparam int CTRL_CLKSTOP = 8;
  localparam int CTRL_INTCLK = 9;
  localparam int CTRL_INTFS = 10;
  localparam int CTRL_CLKPOL = 11;
  localparam int CTRL_FSPOL = 12;
  localparam int CTRL_FSDLY = 13;
  localparam int CTRL_SIGNX = 15;
  localparam logic [31:0] CTRL_WMASK = 32'h0000FFFF;
  localparam logic [2:0] WLEN_8 = 3'h0;
  // Clock configuration and channel base fields
  localparam int CLK_DIV = 0;
  localparam int CLK_FSW = 8;
  localparam int CLK_PER = 16;
  localparam logic [31:0] CLKCFG_WMASK = 32'h0FFFFFFF;
  localparam int CHB_TX = 0;
  localparam int CHB_RX = 8;
  localparam logic [31:0] CHB_WMASK = 32'h00007F7F;
  localparam logic [6:0] LAST_CHAN = 7'h7F;
  // Status bits
  localparam int ST_TXRDY = 0;
  localparam int ST_RXRDY = 1;
  localparam int ST_TXOVW = 2;
  localparam int ST_RXOVR = 3;
  // ==========================================================================
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] CLKCFG_RST = 32'h00000000;
  localparam logic [3:0] MASK_RST = 4'h0;

  // Word length code to bit count minus one
  function automatic logic [4:0] wordLenM1(input logic [2:0] code);
    case (code)
      3'h0: return 5'h07;
      3'h1: return 5'h0B;
      3'h2: return 5'h0F;
      3'h3: return 5'h13;
      3'h4: return 5'h17;
      default: return 5'h1F;
    endcase
  endfunction : wordLenM1
endpackage : mbsp_pkg

/* core/mbsp_port.sv */
// Buffered serial port: register slave, clock and frame generator,
// transmit and receive sections. Assumes link pins arrive asynchronously
// and toggle at most at half the clock rate; registers on Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module mbsp_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  output logic txEvent,
  output logic rxEvent,
  input wire logic txBitClockIn,
  output logic txBitClockOut,
  output logic txBitClockOe,
  input wire logic txFrameSyncIn,
  output logic txFrameSyncOut,
  output logic txFrameSyncOe,
  output logic txSerialData,
  output logic txSerialDataOe,
  input wire logic rxBitClockIn,
  output logic rxBitClockOut,
  output logic rxBitClockOe,
  input wire logic rxFrameSyncIn,
  output logic rxFrameSyncOut,
  output logic rxFrameSyncOe,
  input wire logic rxSerialData
);
  typedef struct packed {
    logic waitReq;
    logic [31:0] rdData;
    logic [31:0] ctrl;
    logic [31:0] clkCfg;
    logic [31:0] txChEn;
    logic [31:0] rxChEn;
    logic [31:0] chBase;
    logic [3:0] status;
    logic [3:0] mask;
    logic irq;
    logic txEv;
    logic rxEv;
    logic [31:0] txData;
    logic txFull;
    logic [31:0] rxBuf;
    logic rxBufFull;
    logic [31:0] rxData;
    logic rxFull;
    logic [7:0] divCnt;
    logic genClk;
    logic [11:0] frameCnt;
    logic spiBusy;
    logic txClkPrev;
    logic txFsPrev;
    logic txPend;
    logic txInFrame;
    logic [1:0] txSkip;
    logic [4:0] txBit;
    logic [6:0] txChan;
    logic txChOn;
    logic [31:0] txShift;
    logic txOut;
    logic txOe;
    logic rxClkPrev;
    logic rxFsPrev;
    logic rxPend;
    logic rxInFrame;
    logic [1:0] rxSkip;
    logic [4:0] rxBit;
    logic [6:0] rxChan;
    logic rxChOn;
    logic [31:0] rxShift;
    logic txClkOut;
    logic txClkOe;
    logic txFsOut;
    logic txFsOe;
    logic rxClkOut;
    logic rxClkOe;
    logic rxFsOut;
    logic rxFsOe;
  } mbsp_state_t;
  mbsp_state_t s;
  mbsp_state_t n;

  logic [4:0] syn;
  logic [4:0] lenM1;
  logic cmp8, clkStop, intClk, intFs, multi, genFs;
  logic txClkAct, rxClkAct, txFsAct, rxFsAct;
  logic txDrive, rxSample, txFsRise, rxFsRise;
  logic req, accept;
  logic [31:0] txLoad, rxMask, rxWord, rxProc;
  logic [3:0] setEv;

  mbsp_cmp_if cmp();

  // ==========================================================================
  // Pin synchronisers and companding unit
  mbsp_sync #(.WIDTH(5)) u_sync (
    .clk(clk),
    .reset(reset),
    .asyncIn({txBitClockIn, txFrameSyncIn, rxBitClockIn, rxFrameSyncIn,
              rxSerialData}),
    .syncOut(syn)
  );

  mbsp_compand u_compand (
    .cmp(cmp.codec)
  );

  assign cmp.aLaw = s.ctrl[mbsp_pkg::CTRL_ALAW];
  assign cmp.txLinear = s.txData[15:0];
  assign cmp.rxCode = s.rxBuf[7:0];

  // ==========================================================================
  // Decoded configuration and link edges
  assign lenM1 = mbsp_pkg::wordLenM1(s.ctrl[mbsp_pkg::CTRL_WLEN +: 3]);
  assign cmp8 = s.ctrl[mbsp_pkg::CTRL_CMPEN] &&
                (s.ctrl[mbsp_pkg::CTRL_WLEN +: 3] == mbsp_pkg::WLEN_8);
  assign clkStop = s.ctrl[mbsp_pkg::CTRL_CLKSTOP];
  assign intClk = s.ctrl[mbsp_pkg::CTRL_INTCLK];
  assign intFs = s.ctrl[mbsp_pkg::CTRL_INTFS];
  assign multi = s.ctrl[mbsp_pkg::CTRL_MULTI];
  assign genFs = clkStop ? s.spiBusy :
                 (s.frameCnt <= {4'h0, s.clkCfg[mbsp_pkg::CLK_FSW +: 8]});
  assign txClkAct = (intClk ? s.genClk : syn[4]) ^
                    s.ctrl[mbsp_pkg::CTRL_CLKPOL];
  assign rxClkAct = clkStop ? txClkAct : ((intClk ? s.genClk : syn[2]) ^
                    s.ctrl[mbsp_pkg::CTRL_CLKPOL]);
  assign txFsAct = intFs ? genFs : (syn[3] ^ s.ctrl[mbsp_pkg::CTRL_FSPOL]);
  assign rxFsAct = clkStop ? txFsAct :
                   (intFs ? genFs : (syn[1] ^ s.ctrl[mbsp_pkg::CTRL_FSPOL]));
  assign txDrive = txClkAct & ~s.txClkPrev;
  assign rxSample = ~rxClkAct & s.rxClkPrev;
  assign txFsRise = txFsAct & ~s.txFsPrev;
  assign rxFsRise = rxFsAct & ~s.rxFsPrev;
  assign req = avs_read | avs_write;
  assign accept = req & ~s.waitReq;
  assign txLoad = cmp8 ? {cmp.txCode, 24'h000000} :
                  (s.txData << (5'h1F - lenM1));
  assign rxMask = 32'hFFFFFFFF >> (5'h1F - lenM1);
  assign rxWord = s.rxBuf & rxMask;
  assign rxProc = cmp8 ? {{16{cmp.rxLinear[15]}}, cmp.rxLinear} :
                  ((s.ctrl[mbsp_pkg::CTRL_SIGNX] && s.rxBuf[lenM1]) ?
                   (rxWord | ~rxMask) : rxWord);

  // Channel selection within a frame
  function automatic logic chanOn(input logic [6:0] chan,
                                  input logic [6:0] base,
                                  input logic [31:0] en,
                                  input logic mc);
    logic [6:0] rel;
    rel = chan - base;
    if (!mc) return chan == 7'h00;
    return (rel[6:5] == 2'h0) && en[rel[4:0]];
  endfunction : chanOn

  // ==========================================================================
  // Next-state logic
  always_comb begin
    n = s;
    setEv = 4'h0;
    n.txEv = 1'b0;
    n.rxEv = 1'b0;

    // Clock generator; stops between words in clock-stop mode
    if (clkStop && !s.spiBusy) begin
      n.divCnt = 8'h00;
      n.genClk = 1'b0;
      if (intClk && s.txFull && !s.txInFrame && !s.txPend &&
          s.ctrl[mbsp_pkg::CTRL_TXEN]) begin
        n.spiBusy = 1'b1;
      end
    end else if (s.divCnt == s.clkCfg[mbsp_pkg::CLK_DIV +: 8]) begin
      n.divCnt = 8'h00;
      if (s.genClk) begin
        n.genClk = 1'b0;
      end else if (clkStop && !(s.txInFrame | s.txPend | txFsRise)) begin
        n.spiBusy = 1'b0;
      end else begin
        n.genClk = 1'b1;
        n.frameCnt = (s.frameCnt == s.clkCfg[mbsp_pkg::CLK_PER +: 12]) ?
                     12'h000 : (s.frameCnt + 12'h001);
      end
    end else begin
      n.divCnt = s.divCnt + 8'h01;
    end

    // Transmit section
    n.txClkPrev = txClkAct;
    n.txFsPrev = txFsAct;
    n.txPend = s.txPend | (txFsRise & s.ctrl[mbsp_pkg::CTRL_TXEN]);
    if (txDrive) begin
      n.txOe = 1'b0;
      if (n.txPend) begin
        n.txPend = 1'b0;
        n.txInFrame = 1'b1;
        n.txSkip = s.ctrl[mbsp_pkg::CTRL_FSDLY +: 2];
        n.txChan = 7'h00;
        n.txBit = 5'h00;
      end
      if (n.txInFrame) begin
        if (n.txSkip != 2'h0) begin
          n.txSkip = n.txSkip - 2'h1;
        end else begin
          if (n.txBit == 5'h00) begin
            n.txChOn = chanOn(n.txChan, s.chBase[mbsp_pkg::CHB_TX +: 7],
                              s.txChEn, multi);
            n.txShift = 32'h00000000;
            if (n.txChOn && n.txFull) begin
              n.txShift = txLoad;
              n.txFull = 1'b0;
              n.txEv = 1'b1;
              setEv[mbsp_pkg::ST_TXRDY] = 1'b1;
            end
          end
          n.txOut = n.txChOn & n.txShift[31];
          n.txOe = n.txChOn;
          n.txShift = {n.txShift[30:0], 1'b0};
          if (n.txBit == lenM1) begin
            n.txBit = 5'h00;
            if (!multi || n.txChan == mbsp_pkg::LAST_CHAN) begin
              n.txInFrame = 1'b0;
            end
            n.txChan = n.txChan + 7'h01;
          end else begin
            n.txBit = n.txBit + 5'h01;
          end
        end
      end
    end

    // Receive section
    n.rxClkPrev = rxClkAct;
    n.rxFsPrev = rxFsAct;
    n.rxPend = s.rxPend | (rxFsRise & s.ctrl[mbsp_pkg::CTRL_RXEN]);
    if (rxSample) begin
      if (n.rxPend) begin
        n.rxPend = 1'b0;
        n.rxInFrame = 1'b1;
        n.rxSkip = s.ctrl[mbsp_pkg::CTRL_FSDLY +: 2];
        n.rxChan = 7'h00;
        n.rxBit = 5'h00;
      end
      if (n.rxInFrame) begin
        if (n.rxSkip != 2'h0) begin
          n.rxSkip = n.rxSkip - 2'h1;
        end else begin
          if (n.rxBit == 5'h00) begin
            n.rxChOn = chanOn(n.rxChan, s.chBase[mbsp_pkg::CHB_RX +: 7],
                              s.rxChEn, multi);
          end
          n.rxShift = {n.rxShift[30:0], syn[0]};
          if (n.rxBit == lenM1) begin
            n.rxBit = 5'h00;
            if (n.rxChOn) begin
              if (n.rxBufFull) begin
                setEv[mbsp_pkg::ST_RXOVR] = 1'b1;
              end else begin
                n.rxBuf = n.rxShift;
                n.rxBufFull = 1'b1;
              end
            end
            if (!multi || n.rxChan == mbsp_pkg::LAST_CHAN) begin
              n.rxInFrame = 1'b0;
            end
            n.rxChan = n.rxChan + 7'h01;
          end else begin
            n.rxBit = n.rxBit + 5'h01;
          end
        end
      end
    end

    // Register bus: one wait cycle, answer in the following cycle
    n.waitReq = ~(req & s.waitReq);
    if (req && s.waitReq && avs_read) begin
      case (avs_address)
        mbsp_pkg::OFF_CTRL: n.rdData = s.ctrl;
        mbsp_pkg::OFF_CLKCFG: n.rdData = s.clkCfg;
        mbsp_pkg::OFF_TXDATA: n.rdData = s.txData;
        mbsp_pkg::OFF_RXDATA: n.rdData = s.rxData;
        mbsp_pkg::OFF_STATUS: n.rdData = {22'h000000, s.rxFull, s.txFull,
                                          4'h0, s.status};
        mbsp_pkg::OFF_MASK: n.rdData = {28'h0000000, s.mask};
        mbsp_pkg::OFF_TXCHEN: n.rdData = s.txChEn;
        mbsp_pkg::OFF_RXCHEN: n.rdData = s.rxChEn;
        mbsp_pkg::OFF_CHBASE: n.rdData = s.chBase;
        default: n.rdData = 32'h00000000;
      endcase
    end
    if (accept && avs_read && avs_address == mbsp_pkg::OFF_RXDATA) begin
      n.rxFull = 1'b0;
    end
    if (accept && avs_write) begin
      case (avs_address)
        mbsp_pkg::OFF_CTRL: n.ctrl = avs_writedata & mbsp_pkg::CTRL_WMASK;
        mbsp_pkg::OFF_CLKCFG: begin
          n.clkCfg = avs_writedata & mbsp_pkg::CLKCFG_WMASK;
        end
        mbsp_pkg::OFF_TXDATA: begin
          if (n.txFull) begin
            setEv[mbsp_pkg::ST_TXOVW] = 1'b1;
          end
          n.txData = avs_writedata;
          n.txFull = 1'b1;
        end
        mbsp_pkg::OFF_STATUS: n.status = s.status & ~avs_writedata[3:0];
        mbsp_pkg::OFF_MASK: n.mask = avs_writedata[3:0];
        mbsp_pkg::OFF_TXCHEN: n.txChEn = avs_writedata;
        mbsp_pkg::OFF_RXCHEN: n.rxChEn = avs_writedata;
        mbsp_pkg::OFF_CHBASE: n.chBase = avs_writedata & mbsp_pkg::CHB_WMASK;
        default: n.rdData = n.rdData;
      endcase
    end

    // Buffer to data register when the data register is free; waits for
    // the registered buffer so rxProc already sees the new word
    if (s.rxBufFull && !n.rxFull) begin
      n.rxData = rxProc;
      n.rxFull = 1'b1;
      n.rxBufFull = 1'b0;
      n.rxEv = 1'b1;
      setEv[mbsp_pkg::ST_RXRDY] = 1'b1;
    end

    // Sticky status: a new event wins over a clear in the same cycle
    n.status = n.status | setEv;
    n.irq = |(n.status & n.mask);

    // Pin drivers
    n.txClkOut = s.genClk ^ s.ctrl[mbsp_pkg::CTRL_CLKPOL];
    n.txClkOe = intClk;
    n.txFsOut = genFs ^ s.ctrl[mbsp_pkg::CTRL_FSPOL];
    n.txFsOe = intFs;
    n.rxClkOut = s.genClk ^ s.ctrl[mbsp_pkg::CTRL_CLKPOL];
    n.rxClkOe = intClk & ~clkStop;
    n.rxFsOut = genFs ^ s.ctrl[mbsp_pkg::CTRL_FSPOL];
    n.rxFsOe = intFs & ~clkStop;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.waitReq <= 1'b1;
      s.ctrl <= mbsp_pkg::CTRL_RST;
      s.clkCfg <= mbsp_pkg::CLKCFG_RST;
      s.mask <= mbsp_pkg::MASK_RST;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign avs_readdata = s.rdData;
  assign avs_waitrequest = s.waitReq;
  assign irq = s.irq;
  assign txEvent = s.txEv;
  assign rxEvent = s.rxEv;
  assign txBitClockOut = s.txClkOut;
  assign txBitClockOe = s.txClkOe;
  assign txFrameSyncOut = s.txFsOut;
  assign txFrameSyncOe = s.txFsOe;
  assign txSerialData = s.txOut;
  assign txSerialDataOe = s.txOe;
  assign rxBitClockOut = s.rxClkOut;
  assign rxBitClockOe = s.rxClkOe;
  assign rxFrameSyncOut = s.rxFsOut;
  assign rxFrameSyncOe = s.rxFsOe;
endmodule : mbsp_port
`default_nettype wire

/* core/mbsp_port_end.sv */
// Holds no logic; only restores the default net type for the core sources.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* core/mbsp_sync.sv */
// Two-stage synchroniser for pins that arrive from outside the clock domain.
// Assumes the inputs change no faster than every two clock periods.
`timescale 1ns/1ns
`default_nettype none
module mbsp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } mbsp_sync_t;
  mbsp_sync_t s;
  mbsp_sync_t n;

  always_comb begin
    n.stage1 = asyncIn;
    n.stage2 = s.stage1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign syncOut = s.stage2;
endmodule : mbsp_sync
`default_nettype wire

/* verif/mbsp_link_model.sv */
// Far-side codec: makes bit clock and frame sync, sends and captures words.
// Assumes the port samples on falling and drives on rising bit clock edges.
`timescale 1ns/1ns
`default_nettype none
module mbsp_link_model (
  output logic bitClk,
  output logic frameSync,
  output logic rxData,
  input wire logic txWire
);
  initial begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    rxData = 1'b0;
  end
  // Clock stands still outside frames; 64 ns period within
  task automatic frame(input logic [31:0] word, input int bits,
                       output logic [31:0] got);
    got = 32'h00000000;
    #5 frameSync = 1'b1;
    #32;
    for (int i = bits - 1; i >= 0; i--) begin
      bitClk = 1'b1;
      rxData = word[i];
      #32 bitClk = 1'b0;
      frameSync = 1'b0;
      got[i] = txWire;
      #32;
    end
    rxData = ~rxData;
  endtask : frame
endmodule : mbsp_link_model
`default_nettype wire

/* verif/mbsp_port_monitor.sv */
// Checker of the bus handshake, event pulses and transmit pin of the port.
// Assumes it is bound to the port module and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module mbsp_port_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic txEvent,
  input wire logic rxEvent,
  input wire logic txSerialData,
  input wire logic txSerialDataOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ========================================
  // Register bus
  property p_wait_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("no answer");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("long answer");
  property p_wait_idle;
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("stray answer");
  property p_after_reset;
    $fell(reset) |-> avs_waitrequest && !irq && !txEvent && !txSerialDataOe;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("reset state");
  // ========================================
  // Events and link
  property p_tx_pulse;
    txEvent |=> !txEvent;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx event long");
  property p_rx_pulse;
    rxEvent |=> !rxEvent;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx event long");
  property p_tx_load;
    txEvent |-> ##[0:2] txSerialDataOe;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("load not sent");
  property p_tx_rate;
    txSerialDataOe && $changed(txSerialData) |=> $stable(txSerialData);
  endproperty
  a_tx_rate: assert property (p_tx_rate) else $error("tx bit too fast");
endmodule : mbsp_port_monitor
bind mbsp_port mbsp_port_monitor u_mon (.clk(clk), .reset(reset),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .txEvent(txEvent),
  .rxEvent(rxEvent), .txSerialData(txSerialData),
  .txSerialDataOe(txSerialDataOe));
`default_nettype wire

/* verif/mbsp_port_tb.sv */
// Self-checking bench of the port: registers over Avalon-MM, link frames.
// Assumes the link model drives external clock and frame sync pins.
`timescale 1ns/1ns
`default_nettype none
module mbsp_port_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic [31:0] rdata;
  logic waitReq, irq, txEv, rxEv, txD, txDOe;
  logic txCO, txCOe, txFO, txFOe, rxCO, rxCOe, rxFO, rxFOe;
  wire logic lClk, lFs, lRx, txWire;
  int failures = 0;
  int checksDone = 0;
  assign txWire = txDOe ? txD : 1'b1;
  always #2 clk = ~clk;
  mbsp_port u_dut (.clk(clk), .reset(reset), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_readdata(rdata), .avs_waitrequest(waitReq), .irq(irq),
    .txEvent(txEv), .rxEvent(rxEv),
    .txBitClockIn(txCOe ? txCO : lClk), .txBitClockOut(txCO),
    .txBitClockOe(txCOe), .txFrameSyncIn(txFOe ? txFO : lFs),
    .txFrameSyncOut(txFO), .txFrameSyncOe(txFOe), .txSerialData(txD),
    .txSerialDataOe(txDOe), .rxBitClockIn(rxCOe ? rxCO : lClk),
    .rxBitClockOut(rxCO), .rxBitClockOe(rxCOe),
    .rxFrameSyncIn(rxFOe ? rxFO : lFs), .rxFrameSyncOut(rxFO),
    .rxFrameSyncOe(rxFOe), .rxSerialData(lRx));
  mbsp_link_model u_link (.bitClk(lClk), .frameSync(lFs), .rxData(lRx),
    .txWire(txWire));
  // ========================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      failures++;
      stop_test();
    end
  endtask : bus
  task automatic wrReg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wrReg
  task automatic rdChk(input logic [5:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    check(q & m, e);
  endtask : rdChk
  // ========================================
  // Scenarios
  task automatic scnReset();
    rdChk(mbsp_pkg::OFF_CTRL, mbsp_pkg::CTRL_RST, 32'hFFFFFFFF);
    rdChk(mbsp_pkg::OFF_MASK, 32'h00000000, 32'hFFFFFFFF);
    wrReg(6'h3C, 32'hFFFFFFFF);
    rdChk(6'h3C, 32'h00000000, 32'hFFFFFFFF);
  endtask : scnReset
  task automatic scnWordLengths();
    int bits [6] = '{8, 12, 16, 20, 24, 32};
    logic [31:0] got, m, tw, rw;
    for (int c = 0; c < 6; c++) begin
      m = (bits[c] == 32) ? 32'hFFFFFFFF : (32'h00000001 << bits[c]) - 1;
      tw = 32'hC3A596E1 + c;
      rw = 32'h5A3CE187 ^ c;
      wrReg(mbsp_pkg::OFF_CTRL, {27'h0, c[2:0], 2'h3});
      wrReg(mbsp_pkg::OFF_TXDATA, tw);
      u_link.frame(rw, bits[c], got);
      repeat (20) @(posedge clk);
      check(got & m, tw & m);
      rdChk(mbsp_pkg::OFF_RXDATA, rw & m, 32'hFFFFFFFF);
    end
  endtask : scnWordLengths
  task automatic scnCompand();
    logic [31:0] got;
    wrReg(mbsp_pkg::OFF_CTRL, 32'h00000023);
    wrReg(mbsp_pkg::OFF_TXDATA, 32'h00007FFF);
    u_link.frame(32'h00000000, 8, got);
    repeat (20) @(posedge clk);
    check(got, 32'h00000080);
    rdChk(mbsp_pkg::OFF_RXDATA, 32'hFFFF8284, 32'hFFFFFFFF);
    wrReg(mbsp_pkg::OFF_CTRL, 32'h00000063);
    wrReg(mbsp_pkg::OFF_TXDATA, 32'h00000000);
    u_link.frame(32'h000000D5, 8, got);
    repeat (20) @(posedge clk);
    check(got, 32'h000000D5);
    rdChk(mbsp_pkg::OFF_RXDATA, 32'h00000008, 32'hFFFFFFFF);
  endtask : scnCompand
  task automatic scnIntClock();
    logic prev;
    int flips;
    flips = 0;
    wrReg(mbsp_pkg::OFF_CLKCFG, 32'h00000001);
    wrReg(mbsp_pkg::OFF_CTRL, 32'h00000600);
    repeat (4) @(posedge clk);
    check({28'h0, txCOe, txFOe, rxCOe, rxFOe}, 32'h0000000F);
    prev = txCO;
    repeat (64) begin
      @(posedge clk);
      flips += (txCO != prev);
      prev = txCO;
    end
    check(flips, 32'h00000020);
  endtask : scnIntClock
  task automatic scnOverrun();
    logic [31:0] got;
    int n;
    wrReg(mbsp_pkg::OFF_CTRL, 32'h00008003);
    wrReg(mbsp_pkg::OFF_MASK, 32'h00000008);
    wrReg(mbsp_pkg::OFF_STATUS, 32'h0000000F);
    wrReg(mbsp_pkg::OFF_TXDATA, 32'h00000011);
    fork
      u_link.frame(32'h000000A1, 8, got);
      begin
        n = 0;
        while (txEv !== 1'b1 && n < 400) begin
          @(posedge clk);
          n++;
        end
        check({31'h0, n < 400}, 32'h00000001);
        wrReg(mbsp_pkg::OFF_TXDATA, 32'h00000022);
      end
    join
    check(got, 32'h00000011);
    u_link.frame(32'h000000B2, 8, got);
    check(got, 32'h00000022);
    u_link.frame(32'h000000C3, 8, got);
    repeat (20) @(posedge clk);
    check({31'h0, irq}, 32'h00000001);
    rdChk(mbsp_pkg::OFF_STATUS, 32'h00000008, 32'h0000000C);
    rdChk(mbsp_pkg::OFF_RXDATA, 32'hFFFFFFA1, 32'hFFFFFFFF);
    rdChk(mbsp_pkg::OFF_RXDATA, 32'hFFFFFFB2, 32'hFFFFFFFF);
    wrReg(mbsp_pkg::OFF_STATUS, 32'h00000008);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h00000000);
    wrReg(mbsp_pkg::OFF_TXDATA, 32'h00000033);
    wrReg(mbsp_pkg::OFF_TXDATA, 32'h00000044);
    rdChk(mbsp_pkg::OFF_STATUS, 32'h00000004, 32'h00000004);
  endtask : scnOverrun
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    scnReset();
    scnWordLengths();
    scnCompand();
    scnOverrun();
    scnIntClock();
    stop_test();
  end
endmodule : mbsp_port_tb
`default_nettype wire
